// ===== shared/drd_defs.svh
// Constants for the converter register write decoder: geometry,
// address codes, set bases and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DRD_DEFS_SVH
`define DRD_DEFS_SVH

// ==========================================================================
// Geometry
`define DRD_CH_NUM        4
`define DRD_SET_NUM       22
`define DRD_MEM_DEPTH     88
`define DRD_CMD_W         29
`define DRD_CTRL_W        28

// ==========================================================================
// Converter class codes (upper address bits)
`define DRD_CLS_FORCE     3'h1
`define DRD_CLS_CLAMP_LO  3'h2
`define DRD_CLS_CLAMP_HI  3'h3
`define DRD_CLS_CMP_LO    3'h4
`define DRD_CLS_CMP_HI    3'h5
`define DRD_RANGE_MAX     3'h5
`define DRD_CLAMP_CODE    2'h2

// ==========================================================================
// Register set bases
`define DRD_BASE_FORCE    5'h00
`define DRD_BASE_CLAMP_LO 5'h06
`define DRD_BASE_CLAMP_HI 5'h08
`define DRD_BASE_CMP_LO   5'h0A
`define DRD_BASE_CMP_HI   5'h10
`define DRD_OFFS_DAC_ADDR 6'h00

// ==========================================================================
// Reset values and correction constants
`define DRD_GAIN_RST      15'h7FFF
`define DRD_OFFS_RST      16'h8000
`define DRD_INPUT_RST     16'h0000
`define DRD_SHARED_RST    16'h0000
`define DRD_GAIN_SHIFT    15
`define DRD_CODE_MID      18'h08000
`define DRD_CODE_MAX      16'hFFFF

`endif

// ===== shared/drd_pkg.sv
// Types shared by the converter register write decoder.
// Assumes drd_defs.svh on the include path.
`include "drd_defs.svh"

package drd_pkg;

  // ========================================================================
  // Target register kind
  typedef enum logic [1:0] {
    TGT_CTRL  = 2'b00,
    TGT_GAIN  = 2'b01,
    TGT_OFFS  = 2'b10,
    TGT_INPUT = 2'b11
  } drd_target_t;

  // ========================================================================
  // Command word as shifted in by the serial interface
  typedef struct packed {
    logic        rw;
    logic [3:0]  ch_sel;
    drd_target_t target;
    logic [5:0]  addr;
    logic [15:0] data;
  } drd_cmd_t;

  // ========================================================================
  // Registered state of the decoder apart from the register stores
  typedef struct packed {
    logic                  x2_load;
    logic [3:0]            x2_mask;
    logic [4:0]            x2_set;
    logic [15:0]           x2_input;
    logic [3:0][15:0]      x2_code;
    logic                  ctrl_wr;
    logic                  ctrl_rd;
    logic [27:0]           ctrl_word;
    logic                  rd_valid;
    logic [15:0]           rd_data;
    logic [15:0]           shared_code;
    logic [3:0][3:0][15:0] clamp_x2;
    logic [3:0][15:0]      clamp_low;
    logic [3:0][15:0]      clamp_high;
    logic [3:0]            clamp_volt;
  } drd_state_t;

endpackage

// ===== rtl/drd_code_calc.sv
// Corrected code calculator for one channel.
// Assumes gain and offset come from the coefficient store, purely comb.
`timescale 1ns/100ps
`default_nettype none
`include "drd_defs.svh"

module drd_code_calc (
  // Operands
  input  wire logic [15:0] input_code_i,
  input  wire logic [14:0] gain_i,
  input  wire logic [15:0] offset_i,
  // Result
  output logic      [15:0] corrected_code_o
);

  logic [31:0] prod;
  logic [17:0] sum;

  // ========================================================================
  // Scale by (gain+1)/2^15, add offset minus mid-scale, saturate
  always_comb begin
    prod = 32'(input_code_i) * 32'({1'b0, gain_i} + 16'h0001);
    sum  = 18'(prod >> `DRD_GAIN_SHIFT) + 18'(offset_i);
    if (sum < `DRD_CODE_MID) begin
      corrected_code_o = 16'h0000;       // Below zero clips low
    end else if (sum - `DRD_CODE_MID > 18'(`DRD_CODE_MAX)) begin
      corrected_code_o = `DRD_CODE_MAX;
    end else begin
      corrected_code_o = 16'(sum - `DRD_CODE_MID);
    end
  end

endmodule // drd_code_calc
`default_nettype wire

// ===== rtl/drd_decoder.sv
// Converter register write decoder: turns command words into writes of
// gain, offset and input registers per channel, and recomputes codes.
// Assumes cmd_valid_i is a one-cycle pulse on clk_sys_i from the shifter.
//
// What this block does
// RULE1 - Command is 29 bits: rw, four channel bits, target, address, data.
// RULE2 - Top bit 0 writes the register; 1 starts a readback instead.
// RULE3 - Every set channel bit receives the write in the same command.
// RULE4 - Target 00 control, 01 gain, 10 offset, 11 input register.
// RULE5 - Upper address bits pick the register set class, lower the converter.
// RULE6 - Input and offset hold 16 bits; gain keeps data bits 15 to 1.
// RULE7 - Force and compare converters have six sets; clamps have two.
// RULE8 - Only input loads recompute the corrected code; coefficients do not.
// RULE9 - One shared offset converter, input register only, via channel bits.
// RULE10 - Host writes shared offset with target 11 and address zero.
// RULE11 - Readback uses the same address decoding as writes.
// RULE12 - Forcing voltage loads clamps from their current-range sets.
// RULE13 - Forcing current loads clamps from their voltage-range sets.
// RULE14 - Host issues only documented address and target combinations.
// RULE15 - Force addresses 001000..001101 pick 5u,20u,200u,2m,ext,voltage.
// RULE16 - Clamp addresses x100 current, x101 voltage, register by target.
// RULE17 - Host keeps low clamp below 0x8000 and high clamp at or above.
// RULE18 - Target 00 writes go to the control decoder, converters untouched.
`timescale 1ns/100ps
`default_nettype none
`include "drd_defs.svh"

module drd_decoder
  import drd_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Command word from the serial interface
  input  wire logic             cmd_valid_i,
  input  wire drd_cmd_t         cmd_word_i,
  // Per-channel force mode, 1 = forcing current
  input  wire logic [3:0]       force_current_i,
  // Corrected code load
  output logic                  x2_load_o,
  output logic      [3:0]       x2_mask_o,
  output logic      [4:0]       x2_set_o,
  output logic      [15:0]      x2_input_o,
  output logic      [3:0][15:0] x2_code_o,
  // Control register decoder hand-off
  output logic                  ctrl_wr_o,
  output logic                  ctrl_rd_o,
  output logic      [27:0]      ctrl_word_o,
  // Readback
  output logic                  rd_valid_o,
  output logic      [15:0]      rd_data_o,
  // Shared offset converter and clamp levels
  output logic      [15:0]      shared_code_o,
  output logic      [3:0][15:0] clamp_low_o,
  output logic      [3:0][15:0] clamp_high_o,
  output logic      [3:0]       clamp_volt_o
);

  drd_state_t       state_ff;
  drd_state_t       nxt_state;

  // Coefficient and input stores, index = channel * 22 + set
  logic [14:0] gain_mem  [`DRD_MEM_DEPTH];
  logic [15:0] offs_mem  [`DRD_MEM_DEPTH];
  logic [15:0] input_mem [`DRD_MEM_DEPTH];

  logic             wr_cmd;
  logic             rd_cmd;
  logic             set_ok;
  logic [4:0]       set_idx;
  logic             shared_hit;
  logic             clamp_set;
  logic [1:0]       clamp_slot;
  logic [3:0][6:0]  mem_idx;
  logic [3:0][15:0] calc_code;
  logic [1:0]       rd_ch;

  // ========================================================================
  // Address decode: class from upper bits, converter from lower
  function automatic logic [5:0] dec_set(input logic [5:0] a);
    logic       ok;
    logic [4:0] s;
    ok = 1'b0;
    s  = 5'h00;
    unique case (a[5:3])
      `DRD_CLS_FORCE: begin                           // [RULE15]
        ok = a[2:0] <= `DRD_RANGE_MAX;
        s  = `DRD_BASE_FORCE + {2'b00, a[2:0]};
      end
      `DRD_CLS_CMP_LO: begin                          // [RULE7]
        ok = a[2:0] <= `DRD_RANGE_MAX;
        s  = `DRD_BASE_CMP_LO + {2'b00, a[2:0]};
      end
      `DRD_CLS_CMP_HI: begin
        ok = a[2:0] <= `DRD_RANGE_MAX;
        s  = `DRD_BASE_CMP_HI + {2'b00, a[2:0]};
      end
      `DRD_CLS_CLAMP_LO: begin                        // [RULE16]
        ok = a[2:1] == `DRD_CLAMP_CODE;
        s  = `DRD_BASE_CLAMP_LO + {4'h0, a[0]};
      end
      `DRD_CLS_CLAMP_HI: begin
        ok = a[2:1] == `DRD_CLAMP_CODE;
        s  = `DRD_BASE_CLAMP_HI + {4'h0, a[0]};
      end
      default: begin
        ok = 1'b0;                                    // Reserved, ignored
        s  = 5'h00;
      end
    endcase
    return {ok, s};
  endfunction

  // ========================================================================
  // Command classification
  always_comb begin
    wr_cmd     = cmd_valid_i & ~cmd_word_i.rw;        // [RULE2]
    rd_cmd     = cmd_valid_i & cmd_word_i.rw;         // [RULE1]
    {set_ok, set_idx} = dec_set(cmd_word_i.addr);     // [RULE5] [RULE11]
    shared_hit = (cmd_word_i.addr == `DRD_OFFS_DAC_ADDR) &
                 (cmd_word_i.target == TGT_INPUT) &
                 (|cmd_word_i.ch_sel);                // [RULE9] [RULE10]
    clamp_set  = (set_idx >= `DRD_BASE_CLAMP_LO) &
                 (set_idx <  `DRD_BASE_CMP_LO);
    clamp_slot = {set_idx >= `DRD_BASE_CLAMP_HI, cmd_word_i.addr[0]};
    rd_ch      = 2'd0;
    // Only one channel may be read; the lowest selected one wins
    for (int i = 3; i >= 0; i--) begin
      if (cmd_word_i.ch_sel[i]) begin
        rd_ch = 2'(i);
      end
    end
    for (int i = 0; i < 4; i++) begin
      mem_idx[i] = 7'(i * `DRD_SET_NUM) + {2'b00, set_idx};
    end
  end

  // ========================================================================
  // One calculator per channel so a broadcast load costs one cycle
  for (genvar g = 0; g < `DRD_CH_NUM; g++) begin : g_calc
    drd_code_calc u_calc (
      .input_code_i     (cmd_word_i.data),
      .gain_i           (gain_mem[mem_idx[g]]),
      .offset_i         (offs_mem[mem_idx[g]]),
      .corrected_code_o (calc_code[g])
    );
  end

  // ========================================================================
  // Register stores; kept outside the state struct because of their size
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < `DRD_MEM_DEPTH; k++) begin
        gain_mem[k]  <= `DRD_GAIN_RST;
        offs_mem[k]  <= `DRD_OFFS_RST;
        input_mem[k] <= `DRD_INPUT_RST;
      end
    end else if (wr_cmd && set_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (cmd_word_i.ch_sel[i]) begin                  // [RULE3]
          unique case (cmd_word_i.target)                // [RULE4]
            TGT_GAIN:  gain_mem[mem_idx[i]] <= cmd_word_i.data[15:1]; // [RULE6]
            TGT_OFFS:  offs_mem[mem_idx[i]] <= cmd_word_i.data;
            TGT_INPUT: input_mem[mem_idx[i]] <= cmd_word_i.data;
            TGT_CTRL: ;                                  // [RULE18]
          endcase
        end
      end
    end
  end

  // ========================================================================
  // Next state of outputs and cached codes
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.x2_load  = 1'b0;
    nxt_state.ctrl_wr  = 1'b0;
    nxt_state.ctrl_rd  = 1'b0;
    nxt_state.rd_valid = 1'b0;
    // Control writes leave every converter register alone
    if (wr_cmd && cmd_word_i.target == TGT_CTRL) begin
      nxt_state.ctrl_wr   = 1'b1;                        // [RULE18]
      nxt_state.ctrl_word = cmd_word_i[27:0];
    end
    if (wr_cmd && shared_hit) begin
      nxt_state.shared_code = cmd_word_i.data;           // [RULE9]
    end
    // Coefficient writes never reach here, so no recompute happens
    if (wr_cmd && set_ok && cmd_word_i.target == TGT_INPUT &&
        |cmd_word_i.ch_sel) begin
      nxt_state.x2_load  = 1'b1;                         // [RULE8]
      nxt_state.x2_mask  = cmd_word_i.ch_sel;
      nxt_state.x2_set   = set_idx;
      nxt_state.x2_input = cmd_word_i.data;
      for (int i = 0; i < 4; i++) begin
        if (cmd_word_i.ch_sel[i]) begin                  // [RULE3]
          nxt_state.x2_code[i] = calc_code[i];
          if (clamp_set) begin
            nxt_state.clamp_x2[i][clamp_slot] = calc_code[i];
          end
        end
      end
    end
    // Readback: control kinds go on, converters answer here
    if (rd_cmd) begin
      if (cmd_word_i.target == TGT_CTRL) begin
        nxt_state.ctrl_rd   = 1'b1;
        nxt_state.ctrl_word = cmd_word_i[27:0];
      end else if (shared_hit) begin
        nxt_state.rd_valid = 1'b1;
        nxt_state.rd_data  = state_ff.shared_code;
      end else if (set_ok && |cmd_word_i.ch_sel) begin
        nxt_state.rd_valid = 1'b1;                       // [RULE11]
        unique case (cmd_word_i.target)
          TGT_GAIN:  nxt_state.rd_data = {gain_mem[mem_idx[rd_ch]], 1'b0};
          TGT_OFFS:  nxt_state.rd_data = offs_mem[mem_idx[rd_ch]];
          default:   nxt_state.rd_data = input_mem[mem_idx[rd_ch]];
        endcase
      end
    end
    // Clamp converters follow the force mode of each channel
    for (int i = 0; i < 4; i++) begin
      nxt_state.clamp_volt[i] = force_current_i[i];      // [RULE12] [RULE13]
      nxt_state.clamp_low[i]  =
        nxt_state.clamp_x2[i][{1'b0, force_current_i[i]}];
      nxt_state.clamp_high[i] =
        nxt_state.clamp_x2[i][{1'b1, force_current_i[i]}];
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Outputs straight from the state register
  assign x2_load_o     = state_ff.x2_load;
  assign x2_mask_o     = state_ff.x2_mask;
  assign x2_set_o      = state_ff.x2_set;
  assign x2_input_o    = state_ff.x2_input;
  assign x2_code_o     = state_ff.x2_code;
  assign ctrl_wr_o     = state_ff.ctrl_wr;
  assign ctrl_rd_o     = state_ff.ctrl_rd;
  assign ctrl_word_o   = state_ff.ctrl_word;
  assign rd_valid_o    = state_ff.rd_valid;
  assign rd_data_o     = state_ff.rd_data;
  assign shared_code_o = state_ff.shared_code;
  assign clamp_low_o   = state_ff.clamp_low;
  assign clamp_high_o  = state_ff.clamp_high;
  assign clamp_volt_o  = state_ff.clamp_volt;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_coef_no_calc: assert property ( // [RULE8]
    wr_cmd && (cmd_word_i.target inside {TGT_GAIN, TGT_OFFS}) |=> !x2_load_o)
    else $error("coefficient write started a recompute");

  a_input_calc: assert property ( // [RULE8]
    wr_cmd && set_ok && cmd_word_i.target == TGT_INPUT && |cmd_word_i.ch_sel
    |=> x2_load_o && x2_set_o == $past(set_idx))
    else $error("input load did not recompute");

  a_read_no_write: assert property ( // [RULE2]
    rd_cmd |=> !x2_load_o && !ctrl_wr_o)
    else $error("readback caused a write");

  a_ctrl_route: assert property ( // [RULE18]
    wr_cmd && cmd_word_i.target == TGT_CTRL
    |=> ctrl_wr_o && !x2_load_o && ctrl_word_o == $past(cmd_word_i[27:0]))
    else $error("control write misrouted");

  a_mask_follow: assert property ( // [RULE3]
    x2_load_o |-> x2_mask_o == $past(cmd_word_i.ch_sel))
    else $error("channel mask lost");

  a_x2_data: assert property ( // [RULE6]
    x2_load_o |-> x2_input_o == $past(cmd_word_i.data))
    else $error("input data not taken whole");

  a_shared_wr: assert property ( // [RULE9]
    wr_cmd && shared_hit |=> shared_code_o == $past(cmd_word_i.data))
    else $error("shared offset not written");

  a_read_answer: assert property ( // [RULE11]
    rd_cmd && set_ok && cmd_word_i.target != TGT_CTRL && |cmd_word_i.ch_sel
    |=> rd_valid_o ##1 (!rd_valid_o || $past(rd_cmd)))
    else $error("readback answer missing");

  a_clamp_mode: assert property ( // [RULE13]
    1'b1 |=> clamp_volt_o == $past(force_current_i))
    else $error("clamp set not following force mode");

  // Clamp levels move only on a mode change or a clamp input load
  a_clamp_hold: assert property ( // [RULE12]
    $stable(force_current_i) &&
    !(wr_cmd && clamp_set && cmd_word_i.target == TGT_INPUT)
    |=> $stable(clamp_low_o) && $stable(clamp_high_o))
    else $error("clamp level moved without a cause");

endmodule // drd_decoder
`default_nettype wire

// ===== sim/drd_host_model.sv
// Host controller model: issues command words to the decoder.
// Assumes the bench calls its tasks; drives just after the rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "drd_defs.svh"

module drd_host_model
  import drd_pkg::*;
(
  // Clock
  input  wire logic     clk_sys_i,
  // Command bus toward the decoder
  output var  logic     cmd_valid_o,
  output var  drd_cmd_t cmd_word_o
);
  // ========================================
  // Idle bus at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o  = '0;
  end

  // Documented address and target pairs only; the rest stays unused
  function automatic bit legal(drd_target_t t, logic [5:0] a);
    if (t == TGT_CTRL) return 1'b1;
    if (a == `DRD_OFFS_DAC_ADDR) return (t == TGT_INPUT);
    case (a[5:3])
      3'h1, 3'h4, 3'h5: return (a[2:0] <= 3'h5);
      3'h2, 3'h3: return (a[2:1] == 2'h2);
      default: return 1'b0;
    endcase
  endfunction

  // One command: raised after an edge, taken at the next, then released
  task automatic send(input logic rw, input logic [3:0] ch,
                      input drd_target_t t, input logic [5:0] a,
                      input logic [15:0] d);
    drd_cmd_t w;
    if (!legal(t, a)) return;
    w = '{rw, ch, t, a, d};
    // Low clamp kept below mid-scale, high clamp at or above it
    if (t == TGT_INPUT && a[5:3] == `DRD_CLS_CLAMP_LO) w.data[15] = 1'b0;
    if (t == TGT_INPUT && a[5:3] == `DRD_CLS_CLAMP_HI) w.data[15] = 1'b1;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_word_o  <= w;
    @(posedge clk_sys_i);
    // Released word shows the inverse, so no stale match is possible
    cmd_valid_o <= 1'b0;
    cmd_word_o  <= drd_cmd_t'(~w);
  endtask
endmodule // drd_host_model
`default_nettype wire

// ===== sim/dac_register_write_decoder_tb.sv
// Self-checking bench for the converter register write decoder.
// Assumes drd_pkg compiled first; the host model drives the command bus.
`timescale 1ns/100ps
`default_nettype none
`include "drd_defs.svh"

module dac_register_write_decoder_tb
  import drd_pkg::*;
;
  // ========================================
  // Design ports, bookkeeping and register mirror
  logic             clk_sys_i;
  logic             sys_rst_i;
  logic             cmd_valid;
  drd_cmd_t         cmd_word;
  logic [3:0]       force_current;
  logic             x2_load;
  logic [3:0]       x2_mask;
  logic [4:0]       x2_set;
  logic [15:0]      x2_input;
  logic [3:0][15:0] x2_code;
  logic             ctrl_wr;
  logic             ctrl_rd;
  logic [27:0]      ctrl_word;
  logic             rd_valid;
  logic [15:0]      rd_data;
  logic [15:0]      shared_code;
  logic [3:0][15:0] clamp_low;
  logic [3:0][15:0] clamp_high;
  logic [3:0]       clamp_volt;
  int               num_errors;
  int               checked;
  int               seed;
  logic [14:0]      gain_m [4][22];
  logic [15:0]      offs_m [4][22];
  logic [15:0]      x1_m   [4][22];
  logic [15:0]      x2e    [4];

  drd_host_model u_drd_host_model (
    .clk_sys_i   (clk_sys_i),
    .cmd_valid_o (cmd_valid),
    .cmd_word_o  (cmd_word)
  );

  drd_decoder u_drd_decoder (
    .clk_sys_i       (clk_sys_i),
    .sys_rst_i       (sys_rst_i),
    .cmd_valid_i     (cmd_valid),
    .cmd_word_i      (cmd_word),
    .force_current_i (force_current),
    .x2_load_o       (x2_load),
    .x2_mask_o       (x2_mask),
    .x2_set_o        (x2_set),
    .x2_input_o      (x2_input),
    .x2_code_o       (x2_code),
    .ctrl_wr_o       (ctrl_wr),
    .ctrl_rd_o       (ctrl_rd),
    .ctrl_word_o     (ctrl_word),
    .rd_valid_o      (rd_valid),
    .rd_data_o       (rd_data),
    .shared_code_o   (shared_code),
    .clamp_low_o     (clamp_low),
    .clamp_high_o    (clamp_high),
    .clamp_volt_o    (clamp_volt)
  );

  // ========================================
  // Clock at 40 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well beyond the roughly two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    give_verdict();
  end

  // ========================================
  // Helpers
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Corrected code with saturation, from the mirrored coefficients
  function automatic logic [15:0] calc(int c, int s, logic [15:0] x);
    longint v;
    v = longint'(x) * (longint'(gain_m[c][s]) + 1) / 32768;
    v = v + longint'(offs_m[c][s]) - 32768;
    if (v < 0) return 16'h0000;
    if (v > 65535) return 16'hFFFF;
    return v[15:0];
  endfunction

  function automatic int set_of(logic [5:0] a);
    case (a[5:3])
      3'h1: return a[2:0];
      3'h2: return 6 + a[0];
      3'h3: return 8 + a[0];
      3'h4: return 10 + a[2:0];
      default: return 16 + a[2:0];
    endcase
  endfunction

  // Write one register on every selected channel and check the outcome
  task automatic wr(logic [3:0] ch, drd_target_t t, logic [5:0] a,
                    logic [15:0] d);
    int s;
    bit cv;
    s = set_of(a);
    cv = (a != 6'h00) && (t != TGT_CTRL);
    u_drd_host_model.send(1'b0, ch, t, a, d);
    #1;
    for (int c = 0; c < 4; c++) begin
      if (cv && ch[c] && t == TGT_GAIN) gain_m[c][s] = d[15:1];
      if (cv && ch[c] && t == TGT_OFFS) offs_m[c][s] = d;
      if (cv && ch[c] && t == TGT_INPUT) x1_m[c][s] = d;
      if (cv && ch[c] && t == TGT_INPUT) x2e[c] = calc(c, s, d);
      check("x2_code", x2_code[c], x2e[c]);
    end
    check("x2_load", x2_load, cv && ch != 0 && t == TGT_INPUT);
    if (cv && ch != 0 && t == TGT_INPUT) begin
      check("x2_mask", x2_mask, ch);
      check("x2_set", x2_set, s);
      check("x2_input", x2_input, d);
    end
  endtask

  task automatic rd(int c, drd_target_t t, logic [5:0] a, logic [15:0] e);
    u_drd_host_model.send(1'b1, 4'(1 << c), t, a, 16'h0000);
    #1;
    check("rd_valid", rd_valid, 1'b1);
    check("rd_load", x2_load, 1'b0);
    check("rd_data", rd_data, e);
  endtask

  // Clamp outputs follow the set chosen by each channel's force mode
  task automatic chk_clamp();
    int s;
    for (int c = 0; c < 4; c++) begin
      s = force_current[c] ? 7 : 6;
      check("clamp_low", clamp_low[c], calc(c, s, x1_m[c][s]));
      check("clamp_high", clamp_high[c], calc(c, s + 2, x1_m[c][s + 2]));
    end
    check("clamp_volt", clamp_volt, force_current);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ========================================
  // Test sequence
  initial begin
    logic [3:0]  ch;
    logic [5:0]  a;
    int          k;
    num_errors = 0;
    checked = 0;
    seed = 32'h02EBE97B;
    sys_rst_i = 1'b1;
    force_current = 4'h0;
    for (int c = 0; c < 4; c++) begin
      x2e[c] = 16'h0000;
      for (int s = 0; s < 22; s++) begin
        gain_m[c][s] = 15'h7FFF;
        offs_m[c][s] = 16'h8000;
        x1_m[c][s] = 16'h0000;
      end
    end
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    check("shared_rst", shared_code, 16'h0000);
    chk_clamp();
    rd(0, TGT_GAIN, 6'h08, 16'hFFFE);
    rd(3, TGT_OFFS, 6'h2D, 16'h8000);
    $display("test reset done");
    // Random sets of force and compare converters, random channel masks
    for (int i = 0; i < 12; i++) begin
      ch = $random(seed);
      k = {$random(seed)} % 18;
      a = (k < 6) ? {3'h1, 3'(k)} : (k < 12) ? {3'h4, 3'(k - 6)}
                                             : {3'h5, 3'(k - 12)};
      wr(ch, TGT_GAIN, a, $random(seed));
      wr(ch, TGT_OFFS, a, $random(seed));
      wr(ch, TGT_INPUT, a, $random(seed));
      if (ch != 0) begin
        k = 0;
        while (!ch[k]) k++;
        rd(k, TGT_GAIN, a, {gain_m[k][set_of(a)], 1'b0});
        rd(k, TGT_OFFS, a, offs_m[k][set_of(a)]);
        rd(k, TGT_INPUT, a, x1_m[k][set_of(a)]);
      end
    end
    // Saturation at both ends of the code range
    wr(4'hF, TGT_GAIN, 6'h0D, 16'hFFFF);
    wr(4'hF, TGT_OFFS, 6'h0D, 16'h0000);
    wr(4'hF, TGT_INPUT, 6'h0D, 16'h0001);
    wr(4'h9, TGT_OFFS, 6'h0D, 16'hFFFF);
    wr(4'h9, TGT_INPUT, 6'h0D, 16'hFFFF);
    wr(4'h0, TGT_INPUT, 6'h08, 16'h5A5A);
    $display("test random done");
    // Control hand-off, shared offset converter
    wr(4'hA, TGT_CTRL, 6'h15, 16'h1234);
    check("ctrl_wr", ctrl_wr, 1'b1);
    check("ctrl_word", ctrl_word, 28'hA151234);
    u_drd_host_model.send(1'b1, 4'h1, TGT_CTRL, 6'h00, 16'h0000);
    #1;
    check("ctrl_rd", ctrl_rd, 1'b1);
    check("ctrl_rd_word", ctrl_word, 28'h1000000);
    wr(4'h3, TGT_INPUT, 6'h00, 16'hC3A5);
    check("shared_code", shared_code, 16'hC3A5);
    rd(2, TGT_INPUT, 6'h00, 16'hC3A5);
    $display("test control done");
    // Clamp sets against force mode
    wr(4'hF, TGT_INPUT, 6'h14, 16'h1234);
    wr(4'hF, TGT_INPUT, 6'h15, 16'h0456);
    wr(4'hF, TGT_INPUT, 6'h1C, 16'h9ABC);
    wr(4'hF, TGT_INPUT, 6'h1D, 16'hF0F0);
    chk_clamp();
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys_i);
      force_current <= (j == 0) ? 4'hA : 4'h5;
      @(posedge clk_sys_i);
      #1;
      chk_clamp();
    end
    wr(4'h2, TGT_INPUT, 6'h15, 16'h0777);
    chk_clamp();
    $display("test clamp done");
    give_verdict();
  end
endmodule // dac_register_write_decoder_tb
`default_nettype wire
